// [dv/sfs_host_model.sv]
// Host model that reads the parameter table over the serial link, mode 0 or 3.
// Assumes the device samples its pins on the same system clock.
module sfs_host_model (
	input  wire logic i_clk_sys,  // System clock.
	input  wire logic i_miso,     // Device data.
	input  wire logic i_miso_oe,  // Device drive enable.
	output logic      o_sclk,     // Serial clock.
	output logic      o_cs_n,     // Chip select, active low.
	output logic      o_mosi      // Host data.
);
	timeunit 1ns;
	timeprecision 1ps;

	logic       cpol = 1'b0;  // Idle level of the serial clock.
	logic       oe_all;       // Enable high at every data sample.
	logic       oe_any;       // Enable high at some data sample.
	logic [7:0] rx;           // Last byte received.

	// Pins start idle.
	initial begin
		o_sclk = 1'b0;
		o_cs_n = 1'b1;
		o_mosi = 1'b0;
	end

	// An unselected data line is not left at its last value.
	always @(posedge i_clk_sys) begin
		if (o_cs_n) begin
			o_mosi <= ~o_mosi;
		end
	end

	// Shifts nb bits MSB first; each clock phase lasts four system clocks.
	task automatic shift(input logic [7:0] tx, input int nb);
		for (int i = 7; i > 7 - nb; i--) begin
			@(posedge i_clk_sys);
			o_sclk <= 1'b0;
			o_mosi <= tx[i];
			repeat (3) @(posedge i_clk_sys);
			@(posedge i_clk_sys);
			rx[i] = i_miso;
			oe_all = oe_all & i_miso_oe;
			oe_any = oe_any | i_miso_oe;
			o_sclk <= 1'b1;
			repeat (3) @(posedge i_clk_sys);
		end
	endtask : shift

	// Opens a read: command, three address bytes high first, one dummy byte.
	task automatic start_frame(input logic [7:0] cmd, input logic [23:0] a);
		@(posedge i_clk_sys);
		o_sclk <= cpol;
		repeat (3) @(posedge i_clk_sys);
		o_cs_n <= 1'b0;
		shift(cmd, 8);
		for (int b = 2; b >= 0; b--) begin
			shift(a[8*b +: 8], 8);
		end
		shift(8'h00, 8);
		oe_all = 1'b1;
		oe_any = 1'b0;
	endtask : start_frame

	// Closes a frame with the clock at its idle level.
	task automatic end_frame();
		@(posedge i_clk_sys);
		o_sclk <= cpol;
		repeat (3) @(posedge i_clk_sys);
		o_cs_n <= 1'b1;
	endtask : end_frame

endmodule : sfs_host_model

// [dv/tb.sv]
// Self-checking bench for the parameter table slice.
// Assumes the host model drives the serial pins.
module tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic       i_clk_sys;       // System clock.
	logic       i_reset;         // Reset, active high.
	logic       sclk;            // Serial clock.
	logic       cs_n;            // Chip select, active low.
	logic       mosi;            // Host data.
	logic       miso;            // Device data.
	logic       miso_oe;         // Device drive enable.
	int         mismatches = 0;  // Failed comparisons.
	int         tests_run  = 0;  // All comparisons.
	logic [7:0] g [16];          // Bytes read in one frame.
	logic [7:0] tab [12] = '{8'hE5, 8'h20, 8'h81, 8'hFF, 8'hFF, 8'hFF,
	                         8'hFF, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'hFF};

	sfs_param_slice DUT (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_spi_sclk(sclk),
		.i_spi_cs_n(cs_n), .i_spi_mosi(mosi), .o_spi_miso(miso), .o_spi_miso_oe(miso_oe));
	sfs_host_model host (.i_clk_sys(i_clk_sys), .i_miso(miso), .i_miso_oe(miso_oe),
		.o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi));

	// Clock of 10 ns.
	initial begin
		i_clk_sys = 1'b0;
		forever #5 i_clk_sys = ~i_clk_sys;
	end

	// Expected byte at an address; outside the slice it reads all ones.
	function automatic logic [7:0] want(input logic [23:0] a);
		if (a >= 24'h30 && a <= 24'h3B) begin
			return tab[a - 24'h30];
		end
		return 8'hFF;
	endfunction : want

	// Counts and reports one comparison.
	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
		end
	endtask : check

	// Prints the counts and the verdict, then stops.
	task automatic finish_test();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : finish_test

	// Reads n bytes into g, then checks that the pins go quiet.
	task automatic rd(input logic [7:0] cmd, input logic [23:0] a, input int n);
		host.start_frame(cmd, a);
		for (int k = 0; k < n; k++) begin
			host.shift(8'hA5, 8);
			g[k] = host.rx;
		end
		host.end_frame();
		repeat (2) @(negedge i_clk_sys);
		check({6'h0, miso_oe, miso}, 8'h00, "pins after frame");
	endtask : rd

	// Whole slice in one frame, field by field.
	task automatic t_table();
		rd(8'h5A, 24'h30, 12);
		check({7'h0, host.oe_all}, 8'h01, "drive enable");
		check({6'h0, g[0][1:0]}, 8'h01, "erase field");
		check(g[1], 8'h20, "erase opcode");
		check({7'h0, g[0][2]}, 8'h01, "granularity");
		check({7'h0, g[0][3]}, 8'h00, "enable needed");
		check({6'h0, g[0][4:3]}, 8'h00, "enable opcode");
		check(g[0], 8'hE5, "caps byte");
		check(g[2], 8'h81, "read caps byte");
		check({6'h0, g[2][2:1]}, 8'h00, "address width");
		check({7'h0, g[2][3]}, 8'h00, "double rate");
		check(g[8], 8'h00, "quad io wait");
		check({5'h0, g[8][7:5] | g[10][7:5]}, 8'h00, "mode bits");
		check(g[9], 8'hFF, "quad io opcode");
		check(g[10], 8'h00, "quad out wait");
		check(g[11], 8'hFF, "quad out opcode");
		for (int k = 3; k < 8; k++) begin
			check(g[k], 8'hFF, "unused byte");
		end
		$display("test table done");
	endtask : t_table

	// Mode 3 reads from starts 3Ah and 33h, the first running past the slice end.
	task automatic t_mode3();
		host.cpol = 1'b1;
		rd(8'h5A, 24'h3A, 3);
		for (int k = 0; k < 3; k++) begin
			check(g[k], want(24'h3A + k), "mode 3 byte");
		end
		rd(8'h5A, 24'h33, 2);
		check(g[0], 8'hFF, "unused 33");
		check(g[1], 8'hFF, "density byte");
		$display("test mode3 done");
	endtask : t_mode3

	// Chip select raised mid-byte, then a clean read.
	task automatic t_abort();
		host.start_frame(8'h5A, 24'h30);
		host.shift(8'hA5, 4);
		host.end_frame();
		rd(8'h5A, 24'h31, 1);
		check(g[0], 8'h20, "after abort");
		$display("test abort done");
	endtask : t_abort

	// Other command bytes leave the data pin undriven.
	task automatic t_bad();
		logic [7:0] cmds [4] = '{8'h03, 8'h5B, 8'hDA, 8'h00};
		for (int k = 0; k < 4; k++) begin
			rd(cmds[k], 24'h30, 2);
			check({7'h0, host.oe_any}, 8'h00, "refused drive");
		end
		$display("test bad done");
	endtask : t_bad

	// Reset in mid-frame quiets the pins; reads work afterwards.
	task automatic t_reset();
		host.start_frame(8'h5A, 24'h30);
		host.shift(8'hA5, 8);
		@(posedge i_clk_sys);
		i_reset <= 1'b1;
		@(negedge i_clk_sys);
		check({6'h0, miso_oe, miso}, 8'h00, "pins in reset");
		repeat (3) @(posedge i_clk_sys);
		i_reset <= 1'b0;
		host.end_frame();
		rd(8'h5A, 24'h38, 1);
		check(g[0], 8'h00, "after reset");
		$display("test reset done");
	endtask : t_reset

	// Main sequence.
	initial begin
		i_reset = 1'b1;
		repeat (12) @(posedge i_clk_sys);
		i_reset <= 1'b0;
		t_table();
		t_abort();
		t_bad();
		t_reset();
		t_mode3();
		finish_test();
	end

	// Run limit against a hang.
	initial begin
		repeat (100000) @(posedge i_clk_sys);
		mismatches++;
		$display("[ERR] %0t run limit reached", $time);
		finish_test();
	end

endmodule : tb

// [src/sfs_param_slice.sv]
// Serial front end that answers the parameter read command from a constant table slice.
// Assumes the serial pins are synchronous to the system clock and each clock phase lasts
// at least three system clocks.
// The next table byte is looked up in the clocks after the last falling edge of a byte,
// and is ready by the next falling edge, a full serial period later, even with one-clock phases.
// A frame cut by reset is not resumed: the host raises chip select and starts anew.
// Addresses outside the slice read as all ones, so a read may run past its end.
//
// Function
// - Byte 30h erase field 01, 31h reads 20h.
// - Byte 30h bit 2 reads one.
// - Byte 30h bit 3 reads zero.
// - Byte 30h bit 4 reads zero.
// - Byte 30h always reads E5h.
// - Byte 32h reads 81h, dual output supported.
// - Address width field reads 00, three bytes.
// - Double rate clocking bit reads zero.
// - Byte 38h wait states zero, reads 00h.
// - Every mode bit count field reads 000.
// - Byte 39h reads FFh.
// - Byte 3Ah reads 00h.
// - Byte 3Bh reads FFh.
// - Command 5Ah, address, dummy, data; select ends.
`include "sfs_regs.svh"

module sfs_param_slice (
	input  wire logic i_clk_sys,     // System clock, 100 MHz.
	input  wire logic i_reset,       // Asynchronous reset, active high.
	input  wire logic i_spi_sclk,    // Serial clock from the host, sampled.
	input  wire logic i_spi_cs_n,    // Chip select, active low.
	input  wire logic i_spi_mosi,    // Serial data from the host.
	output logic      o_spi_miso,    // Serial data to the host.
	output logic      o_spi_miso_oe  // High while the device drives its data pin.
);
	import sfs_pkg::*;

	sfs_rom_if  rom_if ();           // Lookup port to the table.

	sfs_state_t state;               // Transaction phase.
	sfs_state_t next_state;          // Phase after the current rising edge.
	logic       sclk_q;              // Serial clock one cycle ago.
	logic       sclk_known;          // Serial clock has been sampled since reset.
	logic       sclk_rise;           // Rising serial edge inside a frame.
	logic       sclk_fall;           // Falling serial edge inside a frame.
	logic [7:0] shift_in;            // Bits received of the current byte.
	logic [7:0] next_byte;           // Byte completed by this rising edge.
	logic [2:0] in_cnt;              // Bits received of the current byte.
	logic       byte_done;           // This rising edge completes a byte.
	logic [1:0] addr_cnt;            // Address bytes received.
	sfs_addr_t  addr;                // Byte address being served.
	logic [7:0] shift_out;           // Bits still to send of the current byte.
	logic [2:0] out_cnt;             // Bits sent of the current byte.

	// Table storage answers the served address one cycle later.
	sfs_rom u_rom (
		.i_clk_sys (i_clk_sys),
		.i_reset   (i_reset),
		.rom_port  (rom_if.rom)
	);

	assign rom_if.addr = addr;

	// Edges count only while chip select is low, and not in the first cycle after reset,
	// when sclk_q still holds its reset level rather than the pin's idle level.
	assign sclk_rise = i_spi_sclk & ~sclk_q & ~i_spi_cs_n & sclk_known;
	assign sclk_fall = ~i_spi_sclk & sclk_q & ~i_spi_cs_n & sclk_known;
	assign next_byte = {shift_in[6:0], i_spi_mosi};
	assign byte_done = sclk_rise && (in_cnt == 3'h7);

	// Track the serial clock so that its edges can be found.
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			sclk_q <= 1'b0;
		end else begin
			sclk_q <= i_spi_sclk;
		end
	end

	// Mark the edge detector valid once sclk_q holds a real sample; a serial clock idling
	// high would otherwise show a false rising edge right after reset.
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			sclk_known <= 1'b0;
		end else begin
			sclk_known <= 1'b1;
		end
	end

	// Gather incoming bits, most significant first, restarting at each selection.
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			shift_in <= 8'h00;
			in_cnt   <= 3'h0;
		end else if (i_spi_cs_n) begin
			shift_in <= 8'h00;
			in_cnt   <= 3'h0;
		end else if (sclk_rise) begin
			// Shift the sampled bit in below the earlier ones.
			shift_in <= next_byte;
			in_cnt   <= in_cnt + 3'h1;
		end
	end

	// Choose the next phase when a byte completes.
	always_comb begin
		next_state = state;
		if (byte_done) begin
			case (state)
				SFS_IDLE: begin
					// Only the parameter read command is served.
					if (next_byte == `SFS_CMD_READ_PARAM) begin
						next_state = SFS_ADDR;
					end else begin
						next_state = SFS_IGNORE;
					end
				end
				SFS_ADDR: begin
					// Three address bytes, then the dummy byte.
					if (addr_cnt == `SFS_ADDR_LAST) begin
						next_state = SFS_DUMMY;
					end
				end
				SFS_DUMMY: begin
					next_state = SFS_DATA;
				end
				default: begin
					// Data and ignored frames run until chip select rises.
					next_state = state;
				end
			endcase
		end
	end

	// Phase register; a high chip select ends any frame at once.
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			state <= SFS_IDLE;
		end else if (i_spi_cs_n) begin
			state <= SFS_IDLE;
		end else begin
			// Otherwise follow the phase chosen above.
			state <= next_state;
		end
	end

	// Collect the address, then step it after each byte sent.
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			addr     <= 24'h000000;
			addr_cnt <= 2'h0;
		end else if (i_spi_cs_n) begin
			addr_cnt <= 2'h0;
		end else if (byte_done && state == SFS_ADDR) begin
			// Address arrives high byte first.
			addr     <= {addr[15:0], next_byte};
			addr_cnt <= addr_cnt + 2'h1;
		end else if (sclk_fall && state == SFS_DATA && out_cnt == 3'h7) begin
			// Last bit of a byte leaves now; the next byte is looked up in time.
			addr <= addr + 24'h000001;
		end
	end

	// Drive data on falling edges, loading a fresh table byte every eighth edge.
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			shift_out  <= 8'hFF;
			out_cnt    <= 3'h0;
			o_spi_miso <= 1'b0;
		end else if (i_spi_cs_n) begin
			out_cnt    <= 3'h0;
			o_spi_miso <= 1'b0;
		end else if (sclk_fall && state == SFS_DATA) begin
			if (out_cnt == 3'h0) begin
				// First bit of a byte comes straight from the table.
				o_spi_miso <= rom_if.data[7];
				shift_out  <= {rom_if.data[6:0], 1'b1};
			end else begin
				// Later bits come from the shifter; ones fill in behind them.
				o_spi_miso <= shift_out[7];
				shift_out  <= {shift_out[6:0], 1'b1};
			end
			out_cnt <= out_cnt + 3'h1;
		end
	end

	// Enable the data pin from the first data edge until chip select rises.
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			o_spi_miso_oe <= 1'b0;
		end else if (i_spi_cs_n) begin
			o_spi_miso_oe <= 1'b0;
		end else if (sclk_fall && state == SFS_DATA) begin
			// The enable rises with the first data bit and stays on to the end of the frame.
			o_spi_miso_oe <= 1'b1;
		end
	end

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_reset);

	// A byte load in the data phase.
	sequence s_byte_load;
		sclk_fall && state == SFS_DATA && out_cnt == 3'h0;
	endsequence

	// A completed dummy byte.
	sequence s_dummy_done;
		byte_done && state == SFS_DUMMY && !i_spi_cs_n;
	endsequence

	// A later bit of a byte in the data phase, taken from the shifter.
	sequence s_bit_shift;
		sclk_fall && state == SFS_DATA && out_cnt != 3'h0;
	endsequence

	// A completed command byte at the start of a frame.
	sequence s_cmd_done;
		byte_done && state == SFS_IDLE && !i_spi_cs_n;
	endsequence

	// A completed address byte.
	sequence s_addr_byte;
		byte_done && state == SFS_ADDR && !i_spi_cs_n;
	endsequence

	// The last bit of a data byte leaving the shifter.
	sequence s_byte_end;
		sclk_fall && state == SFS_DATA && out_cnt == 3'h7 && !i_spi_cs_n;
	endsequence

	// Chip select high ends the frame and releases the data pin.
	a_release_quiet: assert property (i_spi_cs_n |=> !o_spi_miso_oe && state == SFS_IDLE)
		else $error("Frame did not end when chip select rose.");

	// A partial byte in either direction is dropped when chip select rises.
	a_partial_drop: assert property (i_spi_cs_n |=> in_cnt == 3'h0 && out_cnt == 3'h0)
		else $error("Bit counters survived the end of a frame.");

	// The read command opens the address phase.
	a_cmd_accept: assert property (s_cmd_done ##0 (next_byte == `SFS_CMD_READ_PARAM)
		|=> state == SFS_ADDR)
		else $error("Read command did not open the address phase.");

	// Any other command is ignored for the rest of the frame.
	a_bad_command: assert property ((byte_done && state == SFS_IDLE && next_byte != 8'h5A && !i_spi_cs_n)
		|=> state == SFS_IGNORE)
		else $error("Unknown command was not ignored.");

	// Each address byte lands in the low byte, the earlier ones moving up.
	a_addr_capture: assert property (s_addr_byte |=> addr[7:0] == $past(next_byte))
		else $error("Address byte was not captured.");

	// The third address byte leads to the dummy byte.
	a_addr_to_dummy: assert property (s_addr_byte ##0 (addr_cnt == `SFS_ADDR_LAST)
		|=> state == SFS_DUMMY)
		else $error("Dummy phase did not follow the third address byte.");

	// The first two address bytes keep the address phase.
	a_addr_more: assert property (s_addr_byte ##0 (addr_cnt != `SFS_ADDR_LAST)
		|=> state == SFS_ADDR)
		else $error("Address phase ended early.");

	// The dummy byte is waited out in full.
	a_dummy_hold: assert property (state == SFS_DUMMY && !byte_done && !i_spi_cs_n
		|=> state == SFS_DUMMY)
		else $error("Dummy phase ended before its eighth bit.");

	// The data pin never switches on outside the data phase.
	a_ignore_silent: assert property (state != SFS_DATA |=> !o_spi_miso_oe || $past(o_spi_miso_oe))
		else $error("Data pin enabled outside the data phase.");

	// While enabled, the data pin belongs to a data phase.
	a_oe_in_data: assert property (o_spi_miso_oe |-> state == SFS_DATA)
		else $error("Data pin enabled while no data is served.");

	// The last dummy bit opens the data phase.
	a_data_entry: assert property (s_dummy_done |=> state == SFS_DATA)
		else $error("Data phase did not follow the dummy byte.");

	// Between falling edges of a frame the data bit stands.
	a_miso_hold: assert property (!i_spi_cs_n && !sclk_fall |=> $stable(o_spi_miso))
		else $error("Data bit changed without a falling serial edge.");

	// The first bit of a byte comes straight from the table.
	a_first_bit: assert property (s_byte_load ##0 (!i_spi_cs_n) |=> o_spi_miso == $past(rom_if.data[7])
		&& o_spi_miso_oe)
		else $error("First data bit does not match the table.");

	// Later bits of a byte come from the shifter, most significant first.
	a_later_bit: assert property (s_bit_shift |=> o_spi_miso == $past(shift_out[7]))
		else $error("Later data bit does not follow the shifter.");

	// The served address steps once per byte sent.
	a_addr_step: assert property ((sclk_fall && state == SFS_DATA && out_cnt == 3'h7 && !i_spi_cs_n)
		|=> addr == $past(addr) + 24'h000001)
		else $error("Address did not advance after a byte.");

	// Within a byte the served address stands.
	a_addr_hold: assert property (state == SFS_DATA && !i_spi_cs_n && !(sclk_fall && out_cnt == 3'h7)
		|=> $stable(addr))
		else $error("Address moved inside a data byte.");

endmodule : sfs_param_slice

// [src/sfs_pkg.sv]
// Types shared by the parameter table slice.
// Assumes nothing of its surroundings.
package sfs_pkg;

	// Phases of one serial transaction.
	typedef enum logic [2:0] {
		SFS_IDLE,
		SFS_ADDR,
		SFS_DUMMY,
		SFS_DATA,
		SFS_IGNORE
	} sfs_state_t;

	// Byte address carried on the serial bus.
	typedef logic [23:0] sfs_addr_t;

endpackage : sfs_pkg

// [src/sfs_regs.svh]
// Constants of the serial parameter table slice: command, addresses, field values and bytes.
// Assumes inclusion by bare name from every file that decodes or checks the table.
`ifndef SFS_REGS_SVH
`define SFS_REGS_SVH

// Command byte that opens a parameter table read.
`define SFS_CMD_READ_PARAM 8'h5A

// Number of address bytes that follow the command, less one.
`define SFS_ADDR_LAST      2'h2

// Byte addresses served by this slice.
`define SFS_ADDR_CAPS      24'h000030
`define SFS_ADDR_ERASE_OPC 24'h000031
`define SFS_ADDR_READ_CAPS 24'h000032
`define SFS_ADDR_UNUSED    24'h000033
`define SFS_ADDR_WAIT_144  24'h000038
`define SFS_ADDR_OPC_144   24'h000039
`define SFS_ADDR_WAIT_114  24'h00003A
`define SFS_ADDR_OPC_114   24'h00003B

// Field values of the capability byte, low field first.
`define SFS_ERASE_4K       2'h1
`define SFS_WR_GRAN_LARGE  1'h1
`define SFS_VWE_REQUIRED   1'h0
`define SFS_VWE_OPSEL      1'h0
`define SFS_CAPS_FILL      3'h7
`define SFS_ERASE_4K_OPC   8'h20

// Field values of the read capability byte, low field first.
`define SFS_FR_112         1'h1
`define SFS_ADDR_3BYTE     2'h0
`define SFS_DTR            1'h0
`define SFS_FR_122         1'h0
`define SFS_FR_144         1'h0
`define SFS_FR_114         1'h0
`define SFS_READ_FILL      1'h1

// Wait-state, mode-bit and opcode fields of the fast read entries.
`define SFS_WAIT_NONE      5'h00
`define SFS_MODE_NONE      3'h0
`define SFS_OPC_NONE       8'hFF
`define SFS_FILL_BYTE      8'hFF

// Whole bytes that the fields above assemble into.
`define SFS_BYTE_CAPS      8'hE5
`define SFS_BYTE_READ_CAPS 8'h81
`define SFS_BYTE_ZERO      8'h00

// Field positions inside the capability byte.
`define SFS_POS_GRAN       2
`define SFS_POS_VWE_REQ    3
`define SFS_POS_VWE_OPSEL  4

`endif

// [src/sfs_rom.sv]
// Constant table bytes 30h to 3Bh, registered one cycle after the address.
// Assumes the address is held stable while the byte is consumed.
`include "sfs_regs.svh"

module sfs_rom (
	input  wire logic i_clk_sys,  // System clock.
	input  wire logic i_reset,    // Asynchronous reset, active high.
	sfs_rom_if.rom    rom_port    // Lookup port.
);
	import sfs_pkg::*;

	logic [7:0] next_data;  // Byte for the current address.

	// Decode the address into its constant byte; all else reads as ones.
	always_comb begin
		if (rom_port.addr == `SFS_ADDR_CAPS) begin
			next_data = {`SFS_CAPS_FILL, `SFS_VWE_OPSEL, `SFS_VWE_REQUIRED,
			             `SFS_WR_GRAN_LARGE, `SFS_ERASE_4K};
		end else if (rom_port.addr == `SFS_ADDR_ERASE_OPC) begin
			next_data = `SFS_ERASE_4K_OPC;
		end else if (rom_port.addr == `SFS_ADDR_READ_CAPS) begin
			next_data = {`SFS_READ_FILL, `SFS_FR_114, `SFS_FR_144, `SFS_FR_122,
			             `SFS_DTR, `SFS_ADDR_3BYTE, `SFS_FR_112};
		end else if (rom_port.addr == `SFS_ADDR_WAIT_144) begin
			next_data = {`SFS_MODE_NONE, `SFS_WAIT_NONE};
		end else if (rom_port.addr == `SFS_ADDR_OPC_144) begin
			next_data = `SFS_OPC_NONE;
		end else if (rom_port.addr == `SFS_ADDR_WAIT_114) begin
			next_data = {`SFS_MODE_NONE, `SFS_WAIT_NONE};
		end else if (rom_port.addr == `SFS_ADDR_OPC_114) begin
			next_data = `SFS_OPC_NONE;
		end else begin
			next_data = `SFS_FILL_BYTE;
		end
	end

	// Hold the looked-up byte in a register for the shifter.
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			rom_port.data <= `SFS_FILL_BYTE;
		end else begin
			rom_port.data <= next_data;
		end
	end

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_reset);

	a_caps_whole: assert property (rom_port.addr == `SFS_ADDR_CAPS |=> rom_port.data == `SFS_BYTE_CAPS)
		else $error("Capability byte is wrong.");
	a_erase_field: assert property (rom_port.addr == `SFS_ADDR_CAPS |=> rom_port.data[1:0] == 2'h1)
		else $error("Erase size field is wrong.");
	a_erase_opcode: assert property (rom_port.addr == `SFS_ADDR_ERASE_OPC |=> rom_port.data == 8'h20)
		else $error("Erase opcode is wrong.");
	a_gran_bit: assert property ($past(rom_port.addr) == `SFS_ADDR_CAPS |-> rom_port.data[`SFS_POS_GRAN])
		else $error("Write granularity bit is clear.");
	a_vwe_required: assert property ($past(rom_port.addr) == `SFS_ADDR_CAPS |-> !rom_port.data[`SFS_POS_VWE_REQ])
		else $error("Write enable requirement bit is set.");
	a_vwe_opsel: assert property ($past(rom_port.addr) == `SFS_ADDR_CAPS
		|-> rom_port.data[`SFS_POS_VWE_OPSEL:`SFS_POS_VWE_REQ] == 2'h0)
		else $error("Write enable opcode select is wrong.");
	a_read_caps: assert property (rom_port.addr == `SFS_ADDR_READ_CAPS |=> rom_port.data == `SFS_BYTE_READ_CAPS)
		else $error("Read capability byte is wrong.");
	a_addr_width: assert property (rom_port.addr == `SFS_ADDR_READ_CAPS |=> rom_port.data[2:1] == 2'h0)
		else $error("Address width field is wrong.");
	a_dtr_off: assert property (rom_port.addr == `SFS_ADDR_READ_CAPS |=> !rom_port.data[3])
		else $error("Double rate bit is set.");
	a_wait_144: assert property (rom_port.addr == `SFS_ADDR_WAIT_144 |=> rom_port.data == `SFS_BYTE_ZERO)
		else $error("Quad io wait byte is wrong.");
	a_mode_bits: assert property ((rom_port.addr == `SFS_ADDR_WAIT_144 || rom_port.addr == `SFS_ADDR_WAIT_114)
		|=> rom_port.data[7:5] == 3'h0)
		else $error("Mode bit count is not zero.");
	a_opc_144: assert property (rom_port.addr == `SFS_ADDR_OPC_144 |=> rom_port.data == 8'hFF)
		else $error("Quad io opcode is wrong.");
	a_wait_114: assert property (rom_port.addr == `SFS_ADDR_WAIT_114 |=> rom_port.data == `SFS_BYTE_ZERO)
		else $error("Quad output wait byte is wrong.");
	a_opc_114: assert property (rom_port.addr == `SFS_ADDR_OPC_114 |=> rom_port.data == 8'hFF)
		else $error("Quad output opcode is wrong.");
	a_unused_fill: assert property (rom_port.addr == `SFS_ADDR_UNUSED |=> rom_port.data == 8'hFF)
		else $error("Unused byte does not read as ones.");

endmodule : sfs_rom

// [src/sfs_rom_if.sv]
// Lookup port between the serial front end and the table storage.
// Assumes both ends run on the system clock.
interface sfs_rom_if;
	import sfs_pkg::*;

	sfs_addr_t  addr;  // Byte address being looked up.
	logic [7:0] data;  // Registered byte, valid one cycle after addr.

	// Front end drives the address and reads the byte.
	modport ctrl (output addr, input data);
	// Storage reads the address and drives the byte.
	modport rom (input addr, output data);

endinterface : sfs_rom_if
